// ### fpm_pkg.sv
// Package for the front-panel message controller: constants, states and register map
// Summary of operation
// - Drive 16 character positions, 19 target LEDs (the 19th always off) and one status LED.
// - Only trip, critical failure, warning and start-up messages appear without a key press.
// - Non-trip messages use half brightness, and typed setting values show dimmer still.
// - The trip message is at full brightness, with a blinking keyword followed by fault type and trip type.
// - The trip message stays, survives restarts through a retained flag, and any key erases it.
// - A failure message holds until a key press or a clean restart.
// - A warning message holds until a key press or a clean restart.
// - An initialising message shows during start-up, and the display blanks when start-up ends.
// - Keypad messages hold until the next key, or blank after 15 minutes without a key (10 seconds after a completion message, until that time-out expires).
// - The session-end key followed by the confirm key shortens the time-out to 10 seconds.
// - Any time-out expiry drops the access privilege to view-only.
// - The 18 function target LEDs show the functions of the displayed trip.
// - The clear key acts as target reset, and there is no separate reset key.
// - A twenty-key keypad is scanned and decoded.
// - The completion message blanks after 10 seconds without a key, then stays blank; a key in it shows a keypad message.
package fpm_pkg;
   localparam int unsigned CLK_HZ          = 125000000;
   localparam int unsigned LONG_TMO_S      = 900;
   localparam int unsigned SHORT_TMO_S     = 10;
   localparam int unsigned TICK_DIV        = CLK_HZ;
   localparam int unsigned BLINK_DIV       = CLK_HZ / 4;
   localparam int unsigned NUM_CHARS       = 16;
   localparam int unsigned NUM_TARGETS     = 19;
   localparam int unsigned NUM_FUNC        = 18;
   localparam int unsigned NUM_KEYS        = 20;
   localparam int unsigned KEY_ROWS        = 4;
   localparam int unsigned KEY_COLS        = 5;
   localparam int unsigned SCAN_DIV        = 125000;
   localparam logic [3:0]  BRIGHT_FULL     = 4'hF;
   localparam logic [3:0]  BRIGHT_HALF     = 4'h8;
   localparam logic [3:0]  BRIGHT_ECHO     = 4'h4;
   localparam logic [4:0]  KEY_CLEAR       = 5'h00;
   localparam logic [4:0]  KEY_END         = 5'h01;
   localparam logic [4:0]  KEY_CONFIRM     = 5'h02;
   localparam logic [4:0]  KEY_DIGIT0      = 5'h0A;
   localparam logic [4:0]  KEY_DIGIT9      = 5'h13;
   localparam logic [4:0]  KEY_NONE        = 5'h1F;
   localparam logic [3:0]  ADR_STATUS      = 4'h0;
   localparam logic [3:0]  ADR_CONTROL     = 4'h1;
   localparam logic [3:0]  ADR_IRQ_STAT    = 4'h2;
   localparam logic [3:0]  ADR_IRQ_MASK    = 4'h3;
   localparam logic [3:0]  ADR_FAULT       = 4'h4;
   localparam logic [3:0]  ADR_KEY         = 4'h5;
   localparam int unsigned CTL_INIT_DONE   = 0;
   localparam int unsigned CTL_SELFTEST_OK = 1;
   localparam int unsigned CTL_RETAIN      = 2;
   localparam int unsigned CTL_ECHO        = 3;
   localparam int unsigned CTL_STATUS_LED  = 4;
   localparam int unsigned CTL_PRIV_SET    = 5;
   localparam int unsigned IRQ_KEY         = 0;
   localparam int unsigned IRQ_TIMEOUT     = 1;
   localparam int unsigned IRQ_TRIP_CLR    = 2;
   localparam int unsigned IRQ_W           = 3;
   typedef enum logic [2:0] {MSG_BLANK, MSG_INIT, MSG_KEYPAD, MSG_ENDED,
                             MSG_WARN, MSG_FAIL, MSG_TRIP} fpm_msg_type;
endpackage

// ### fpm_top.sv
// Front-panel message controller with keypad scanner and Wishbone registers
`timescale 1ns/1ps
module fpm_top
   import fpm_pkg::*;
#(
   parameter int unsigned LONG_TMO_TICKS  = LONG_TMO_S,
   parameter int unsigned SHORT_TMO_TICKS = SHORT_TMO_S,
   parameter int unsigned TICK_CYCLES     = TICK_DIV,
   parameter int unsigned BLINK_CYCLES    = BLINK_DIV,
   parameter int unsigned SCAN_CYCLES     = SCAN_DIV
)
(
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [5:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   output logic                               irq,
   // Protection events
   input  wire logic                          trip_evt,
   input  wire logic [5:0]                    trip_info,
   input  wire logic [fpm_pkg::NUM_FUNC-1:0]  trip_funcs,
   input  wire logic                          fail_evt,
   input  wire logic                          warn_evt,
   input  wire logic [9:0]                    fault_code,
   input  wire logic                          retained_trip,
   // Keypad matrix
   output logic      [fpm_pkg::KEY_ROWS-1:0]  key_row,
   input  wire logic [fpm_pkg::KEY_COLS-1:0]  key_col,
   // Display
   output fpm_pkg::fpm_msg_type               msg_sel,
   output logic      [3:0]                    disp_bright,
   output logic                               keyword_blink,
   output logic                               disp_on,
   output logic      [fpm_pkg::NUM_TARGETS-1:0] target_led,
   output logic                               status_led,
   output logic                               view_only,
   output logic                               retain_trip_out
);
   fpm_msg_type msg_reg, msg_next;
   logic [31:0] tick_cnt_reg, blink_cnt_reg, scan_cnt_reg, tmo_cnt_reg;
   logic        tick, blink_reg;
   logic [1:0]  row_idx_reg;
   logic [KEY_COLS-1:0] col_s1_reg, col_s2_reg, col_s3_reg;
   logic [4:0]  key_hit_reg, key_code_reg;
   logic        key_down_reg, key_evt_reg, end_armed_reg, short_tmo_reg;
   logic        trip_held_reg, fail_held_reg, warn_held_reg, priv_reg;
   logic [5:0]  trip_info_reg;
   logic [9:0]  code_reg;
   logic [NUM_FUNC-1:0] funcs_reg;
   logic [7:0]  ctl_reg;
   logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_evt;
   logic        init_done_d_reg, tmo_expire;

   // Keypad scan: one row low at a time, columns through three flip-flops
   // SCAN_CYCLES must be at least 4: the synchroniser delays the columns by three edges
   wire         scan_step  = (scan_cnt_reg == SCAN_CYCLES - 1);
   wire         cols_agree = (col_s2_reg == col_s3_reg);
   wire         col_active = cols_agree && (col_s3_reg != {KEY_COLS{1'b1}});
   logic [4:0]  col_code;
   always_comb
   begin
      col_code = KEY_NONE;
      for (int c = KEY_COLS - 1; c >= 0; c--)
         if (!col_s3_reg[c])
            col_code = 5'(row_idx_reg * KEY_COLS + c);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scan_cnt_reg <= 32'h0;
         row_idx_reg  <= 2'h0;
         key_row      <= ~KEY_ROWS'(1);
         col_s1_reg   <= {KEY_COLS{1'b1}};
         col_s2_reg   <= {KEY_COLS{1'b1}};
         col_s3_reg   <= {KEY_COLS{1'b1}};
         key_hit_reg  <= KEY_NONE;
         key_down_reg <= 1'b0;
         key_evt_reg  <= 1'b0;
         key_code_reg <= KEY_NONE;
      end
      else
      begin
         col_s1_reg  <= key_col;
         col_s2_reg  <= col_s1_reg;
         col_s3_reg  <= col_s2_reg;
         key_evt_reg <= 1'b0;
         scan_cnt_reg <= scan_step ? 32'h0 : scan_cnt_reg + 32'h1;
         if (scan_step)
         begin
            // Row 3 ends a full sweep; a key counts once per press
            if (col_active)
               key_hit_reg <= col_code;
            if (row_idx_reg == 2'(KEY_ROWS - 1))
            begin
               if ((col_active ? col_code : key_hit_reg) != KEY_NONE && !key_down_reg)
               begin
                  key_evt_reg  <= 1'b1;
                  key_code_reg <= col_active ? col_code : key_hit_reg;
               end
               key_down_reg <= (col_active ? col_code : key_hit_reg) != KEY_NONE;
               key_hit_reg  <= KEY_NONE;
            end
            row_idx_reg <= 2'(row_idx_reg + 2'h1);
            key_row     <= ~(KEY_ROWS'(1) << 2'(row_idx_reg + 2'h1));
         end
      end
   end

   // One-second tick and blink enable
   assign tick = (tick_cnt_reg == TICK_CYCLES - 1);
   wire   tmo_limit_hit = (tmo_cnt_reg >= (short_tmo_reg ? SHORT_TMO_TICKS : LONG_TMO_TICKS) - 1);
   wire   tmo_run = (msg_reg == MSG_KEYPAD) || (msg_reg == MSG_ENDED);
   assign tmo_expire = tmo_run && tick && tmo_limit_hit && !key_evt_reg;

   // Message selection: trip, failure, warning, keypad
   wire init_fall = ctl_reg[CTL_INIT_DONE] && !init_done_d_reg;
   always_comb
   begin
      msg_next = msg_reg;
      if (trip_held_reg)
         msg_next = MSG_TRIP;
      else if (fail_held_reg)
         msg_next = MSG_FAIL;
      else if (warn_held_reg)
         msg_next = MSG_WARN;
      else if (!ctl_reg[CTL_INIT_DONE])
         msg_next = MSG_INIT;
      else if (init_fall || tmo_expire)
         msg_next = MSG_BLANK;
      else if (key_evt_reg)
         msg_next = (end_armed_reg && key_code_reg == KEY_CONFIRM) ? MSG_ENDED : MSG_KEYPAD;
      else if (msg_reg == MSG_TRIP || msg_reg == MSG_FAIL || msg_reg == MSG_WARN)
         msg_next = MSG_BLANK;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tick_cnt_reg    <= 32'h0;
         blink_cnt_reg   <= 32'h0;
         blink_reg       <= 1'b0;
         tmo_cnt_reg     <= 32'h0;
         msg_reg         <= MSG_INIT;
         end_armed_reg   <= 1'b0;
         short_tmo_reg   <= 1'b0;
         priv_reg        <= 1'b0;
         trip_held_reg   <= 1'b0;
         fail_held_reg   <= 1'b0;
         warn_held_reg   <= 1'b0;
         trip_info_reg   <= 6'h00;
         code_reg        <= 10'h000;
         funcs_reg       <= '0;
         init_done_d_reg <= 1'b0;
      end
      else
      begin
         tick_cnt_reg    <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
         blink_cnt_reg   <= (blink_cnt_reg == BLINK_CYCLES - 1) ? 32'h0 : blink_cnt_reg + 32'h1;
         if (blink_cnt_reg == BLINK_CYCLES - 1)
            blink_reg <= ~blink_reg;
         init_done_d_reg <= ctl_reg[CTL_INIT_DONE];
         msg_reg         <= msg_next;
         // Inactivity counter restarts on every key
         if (key_evt_reg || !tmo_run)
            tmo_cnt_reg <= 32'h0;
         else if (tick)
            tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
         if (key_evt_reg)
         begin
            end_armed_reg <= (key_code_reg == KEY_END);
            if (end_armed_reg && key_code_reg == KEY_CONFIRM)
               short_tmo_reg <= 1'b1;
         end
         if (tmo_expire)
         begin
            short_tmo_reg <= 1'b0;
            priv_reg      <= 1'b0;
         end
         else if (ctl_reg[CTL_PRIV_SET])
            priv_reg <= 1'b1;
         // Any key clears held messages; a new event in the same cycle wins
         if (key_evt_reg)
         begin
            trip_held_reg <= 1'b0;
            fail_held_reg <= 1'b0;
            warn_held_reg <= 1'b0;
         end
         if (init_fall && ctl_reg[CTL_SELFTEST_OK])
         begin
            fail_held_reg <= 1'b0;
            warn_held_reg <= 1'b0;
         end
         // Retained trip is reloaded once start-up completes
         if (init_fall && ctl_reg[CTL_RETAIN])
            trip_held_reg <= 1'b1;
         if (trip_evt)
         begin
            trip_held_reg <= 1'b1;
            trip_info_reg <= trip_info;
            funcs_reg     <= trip_funcs;
         end
         if (fail_evt)
            fail_held_reg <= 1'b1;
         if (warn_evt)
            warn_held_reg <= 1'b1;
         if ((fail_evt || warn_evt) && !trip_evt)
            code_reg <= fault_code;
      end
   end

   // Register bus: single-cycle ack, drops in the following cycle
   wire       wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [3:0] wb_word = wb_adr_i[5:2];
   wire       wr_ctl  = wb_req && wb_we_i && wb_sel_i[0] && (wb_word == ADR_CONTROL);
   wire       wr_stat = wb_req && wb_we_i && wb_sel_i[0] && (wb_word == ADR_IRQ_STAT);
   wire       wr_mask = wb_req && wb_we_i && wb_sel_i[0] && (wb_word == ADR_IRQ_MASK);
   wire [31:0] rd_mux =
      (wb_word == ADR_STATUS)   ? {20'h0, 1'b0, priv_reg, warn_held_reg, fail_held_reg,
                                   trip_held_reg, short_tmo_reg, 3'(msg_reg), 3'h0} :
      (wb_word == ADR_CONTROL)  ? {24'h0, ctl_reg} :
      (wb_word == ADR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
      (wb_word == ADR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
      (wb_word == ADR_FAULT)    ? {16'h0, trip_info_reg, code_reg} :
      (wb_word == ADR_KEY)      ? {26'h0, key_down_reg, key_code_reg} : 32'h0;
   assign irq_evt = {trip_held_reg && key_evt_reg, tmo_expire, key_evt_reg};

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0;
         ctl_reg      <= 8'h00;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq          <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h0;
         if (wr_ctl)
            ctl_reg <= wb_dat_i[7:0];
         if (wr_mask)
            irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
         // Set wins over a write-one clear in the same cycle
         irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_evt;
         irq          <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Display outputs, all from flip-flops
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         msg_sel         <= MSG_INIT;
         disp_bright     <= BRIGHT_HALF;
         keyword_blink   <= 1'b0;
         disp_on         <= 1'b1;
         target_led      <= '0;
         status_led      <= 1'b0;
         view_only       <= 1'b1;
         retain_trip_out <= 1'b0;
      end
      else
      begin
         msg_sel       <= msg_reg;
         disp_bright   <= (msg_reg == MSG_TRIP) ? BRIGHT_FULL :
                          (ctl_reg[CTL_ECHO] && msg_reg == MSG_KEYPAD) ? BRIGHT_ECHO : BRIGHT_HALF;
         keyword_blink <= (msg_reg == MSG_TRIP) && blink_reg;
         disp_on       <= (msg_reg != MSG_BLANK);
         target_led    <= {ctl_reg[CTL_STATUS_LED] & 1'b0,
                           (msg_reg == MSG_TRIP) ? funcs_reg : {NUM_FUNC{1'b0}}};
         status_led    <= ctl_reg[CTL_STATUS_LED];
         view_only     <= !priv_reg;
         retain_trip_out <= trip_held_reg;
      end
   end

   // Expiry with no held message after start-up blanks and drops privilege in the next cycle
   timeout_blank_a: assert property (@(posedge ref_clk) disable iff (rst)
      tmo_expire && !trip_held_reg && !fail_held_reg && !warn_held_reg && ctl_reg[CTL_INIT_DONE]
      |=> msg_reg == MSG_BLANK && !priv_reg)
      else $error("time-out did not blank or drop privilege");
   trip_bright_a: assert property (@(posedge ref_clk) disable iff (rst)
      msg_reg == MSG_TRIP |=> disp_bright == BRIGHT_FULL)
      else $error("trip not at full brightness");
   trip_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
      trip_held_reg |=> msg_reg == MSG_TRIP)
      else $error("trip lost precedence");
   key_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
      key_evt_reg && !trip_evt && !(init_fall && ctl_reg[CTL_RETAIN]) |=> !trip_held_reg)
      else $error("key did not erase trip");
   ended_short_a: assert property (@(posedge ref_clk) disable iff (rst)
      key_evt_reg && end_armed_reg && key_code_reg == KEY_CONFIRM |=> short_tmo_reg)
      else $error("end sequence did not shorten time-out");
   init_shown_a: assert property (@(posedge ref_clk) disable iff (rst)
      !ctl_reg[CTL_INIT_DONE] && !trip_held_reg && !fail_held_reg && !warn_held_reg
      |=> msg_reg == MSG_INIT)
      else $error("initialising message missing");
   targets_a: assert property (@(posedge ref_clk) disable iff (rst)
      msg_reg != MSG_TRIP |=> target_led == '0)
      else $error("targets lit without trip message");
   fail_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      fail_held_reg && !key_evt_reg && !init_fall |=> fail_held_reg)
      else $error("failure dropped without cause");
endmodule

// ### fpm_keypad_model.sv
// Operator model for the twenty-key matrix: one contact closed at a time
`timescale 1ns/1ps
module fpm_keypad_model
   import fpm_pkg::*;
(
   // Matrix
   input  wire logic [fpm_pkg::KEY_ROWS-1:0] key_row,
   output logic      [fpm_pkg::KEY_COLS-1:0] key_col,
   // Operator
   input  wire logic                         press,
   input  wire logic [4:0]                   key_code
);
   import fpm_pkg::*;
   logic [2:0] row_idx;
   logic [2:0] col_idx;
   // Codes are taken row-major across the matrix
   assign row_idx = 3'(key_code / 5'(KEY_COLS));
   assign col_idx = 3'(key_code % 5'(KEY_COLS));
   always_comb
   begin
      // Columns sit at their pull-up level whenever no contact closes
      key_col = '1;
      if (press && (key_code < 5'(NUM_KEYS)) && !key_row[row_idx[1:0]])
         key_col[col_idx] = 1'b0;
   end
endmodule

// ### front_panel_message_control_tb_top.sv
// Self-checking bench for the front-panel message controller
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module front_panel_message_control_tb_top;
   import fpm_pkg::*;
   localparam int BLINK = 4;
   typedef struct {logic [3:0] word; logic [31:0] wdat; logic [31:0] exp;} fpm_row_type;
   logic                  ref_clk   = 1'b0;
   logic                  rst       = 1'b1;
   logic                  wb_cyc_i  = 1'b0;
   logic                  wb_stb_i  = 1'b0;
   logic                  wb_we_i   = 1'b0;
   logic [5:0]            wb_adr_i  = '0;
   logic [3:0]            wb_sel_i  = '0;
   logic [31:0]           wb_dat_i  = '0;
   logic [31:0]           wb_dat_o;
   logic                  wb_ack_o;
   logic                  irq;
   logic                  trip_evt  = 1'b0;
   logic                  fail_evt  = 1'b0;
   logic                  warn_evt  = 1'b0;
   logic [5:0]            trip_info = 6'h2D;
   logic [NUM_FUNC-1:0]   trip_funcs = 18'h2AAAA;
   logic [9:0]            fault_code = 10'h155;
   logic [KEY_ROWS-1:0]   key_row;
   logic [KEY_COLS-1:0]   key_col;
   fpm_msg_type           msg_sel;
   logic [3:0]            disp_bright;
   logic                  keyword_blink;
   logic                  disp_on;
   logic [NUM_TARGETS-1:0] target_led;
   logic                  status_led;
   logic                  view_only;
   logic                  retain_trip_out;
   logic                  kp_press  = 1'b0;
   logic [4:0]            kp_code   = KEY_NONE;
   logic [31:0]           rd_q;
   logic                  b;
   int                    error_cnt = 0;
   int                    n_compared = 0;
   fpm_row_type rows [4] = '{'{ADR_IRQ_MASK, 32'h7, 32'h7}, '{ADR_IRQ_MASK, 32'h0, 32'h0},
                             '{4'hF, 32'hFFFFFFFF, 32'h0}, '{ADR_CONTROL, 32'h10, 32'h10}};
   always #4 ref_clk = ~ref_clk;
   fpm_top #(.LONG_TMO_TICKS(30), .SHORT_TMO_TICKS(8), .TICK_CYCLES(10), .BLINK_CYCLES(BLINK),
             .SCAN_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .trip_evt(trip_evt),
      .trip_info(trip_info), .trip_funcs(trip_funcs), .fail_evt(fail_evt), .warn_evt(warn_evt),
      .fault_code(fault_code), .retained_trip(1'b0), .key_row(key_row), .key_col(key_col),
      .msg_sel(msg_sel), .disp_bright(disp_bright), .keyword_blink(keyword_blink), .disp_on(disp_on),
      .target_led(target_led), .status_led(status_led), .view_only(view_only),
      .retain_trip_out(retain_trip_out));
   fpm_keypad_model i_keypad (.key_row(key_row), .key_col(key_col), .press(kp_press), .key_code(kp_code));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Classic single cycle; the master never assumes the slave latency
   task automatic wb(input logic w, input logic [3:0] word, input logic [31:0] d);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {word, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      // Only the watchdog ends a wait for ack
      do
         @(posedge ref_clk);
      while (wb_ack_o !== 1'b1);
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic evt(input logic [2:0] m);
      @(posedge ref_clk);
      {trip_evt, fail_evt, warn_evt} <= m;
      @(posedge ref_clk);
      {trip_evt, fail_evt, warn_evt} <= 3'h0;
      tick(3);
   endtask
   // Held long enough for a full row sweep plus the input synchroniser
   task automatic press(input logic [4:0] c);
      @(posedge ref_clk);
      kp_press <= 1'b1;
      kp_code  <= c;
      repeat (30) @(posedge ref_clk);
      kp_press <= 1'b0;
      tick(30);
   endtask
   task automatic wait_blank(input int n);
      for (int i = 0; i < n && disp_on !== 1'b0; i++)
         tick(1);
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      tick(20);
      `CHK(msg_sel, MSG_INIT)
      `CHK({disp_bright, disp_on, view_only, target_led}, {4'h8, 2'b11, 19'h0})
      @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         wb(1'b1, rows[i].word, rows[i].wdat);
         wb(1'b0, rows[i].word, 32'h0);
         `CHK(rd_q, rows[i].exp)
      end
      tick(3);
      `CHK(status_led, 1'b1)
      wb(1'b1, ADR_CONTROL, 32'h03);
      tick(3);
      `CHK({msg_sel, disp_on}, {MSG_BLANK, 1'b0})
      evt(3'b100);
      `CHK({msg_sel, disp_bright, retain_trip_out}, {MSG_TRIP, BRIGHT_FULL, 1'b1})
      `CHK(target_led, {1'b0, trip_funcs})
      b = keyword_blink;
      tick(BLINK);
      `CHK(keyword_blink, ~b)
      wb(1'b0, ADR_FAULT, 32'h0);
      `CHK(rd_q & 32'hFC00, 32'hB400)
      evt(3'b011);
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK(rd_q & 32'h338, 32'h330)
      `CHK(irq, 1'b0)
      press(KEY_CLEAR);
      `CHK({msg_sel != MSG_TRIP, retain_trip_out, target_led}, {1'b1, 1'b0, 19'h0})
      wb(1'b0, ADR_IRQ_STAT, 32'h0);
      `CHK(rd_q[2:0], 3'h5)
      wb(1'b1, ADR_IRQ_MASK, 32'h5);
      tick(3);
      `CHK(irq, 1'b1)
      wb(1'b1, ADR_IRQ_STAT, 32'h7);
      tick(3);
      `CHK(irq, 1'b0)
      wb(1'b1, ADR_IRQ_MASK, 32'h0);
      evt(3'b010);
      `CHK({msg_sel, disp_bright, disp_on}, {MSG_FAIL, BRIGHT_HALF, 1'b1})
      wb(1'b0, ADR_FAULT, 32'h0);
      `CHK(rd_q[9:0], fault_code)
      evt(3'b001);
      `CHK(msg_sel, MSG_FAIL)
      press(KEY_DIGIT0);
      `CHK(msg_sel != MSG_FAIL && msg_sel != MSG_WARN, 1'b1)
      evt(3'b001);
      `CHK(msg_sel, MSG_WARN)
      wb(1'b1, ADR_CONTROL, 32'h00);
      wb(1'b1, ADR_CONTROL, 32'h03);
      tick(3);
      `CHK(msg_sel, MSG_BLANK)
      wb(1'b1, ADR_CONTROL, 32'h00);
      wb(1'b1, ADR_CONTROL, 32'h07);
      tick(3);
      `CHK(msg_sel, MSG_TRIP)
      press(KEY_CLEAR);
      `CHK(retain_trip_out, 1'b0)
      wb(1'b1, ADR_CONTROL, 32'h03);
      wait_blank(400);
      press(KEY_DIGIT9);
      `CHK(msg_sel, MSG_KEYPAD)
      wb(1'b1, ADR_CONTROL, 32'h23);
      tick(3);
      `CHK(view_only, 1'b0)
      wb(1'b1, ADR_CONTROL, 32'h0B);
      tick(3);
      `CHK(disp_bright, BRIGHT_ECHO)
      wb(1'b1, ADR_CONTROL, 32'h03);
      tick(100);
      `CHK({msg_sel, disp_bright}, {MSG_KEYPAD, BRIGHT_HALF})
      wait_blank(400);
      `CHK({msg_sel, view_only}, {MSG_BLANK, 1'b1})
      wb(1'b0, ADR_IRQ_STAT, 32'h0);
      `CHK(rd_q[IRQ_TIMEOUT], 1'b1)
      press(KEY_END);
      press(KEY_CONFIRM);
      `CHK(msg_sel, MSG_ENDED)
      wait_blank(100);
      `CHK({msg_sel, view_only}, {MSG_BLANK, 1'b1})
      tick(100);
      `CHK(msg_sel, MSG_BLANK)
      report_and_stop();
   end
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
